// file: src/lfs_frame_store.sv
module lfs_frame_store
  import lfs_pkg::*;
#(
  parameter int FRAME_TICKS = FRAME_CYC,
  parameter int BLINK_TICKS = BLINK_CYC
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_o,
  output logic [NUM_LEDS-1:0]      led_o,
  output logic [2:0]               cur_frame_o,
  output logic                     play_done_o
);

  // ----------------------------------------------------------------
  // Pin conditioning
  // ----------------------------------------------------------------
  logic [1:0] pins_f;
  logic       scl_f;
  logic       sda_f;
  logic       scl_p_q;
  logic       sda_p_q;

  lfs_pin_sync #(.W(2)) u_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({scl_i, sda_i}),
    .level_o (pins_f)
  );

  assign scl_f = pins_f[1];
  assign sda_f = pins_f[0];

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_f & ~scl_p_q;
  assign scl_fall  = ~scl_f & scl_p_q;
  assign bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  function automatic logic [10:0] mem_idx(input logic [2:0] page, input logic [7:0] off);
    mem_idx = 11'(page) * 11'(PAGE_BYTES) + 11'(off);
  endfunction

  // Frame contents have no reset: undefined until the host fills them
  logic [7:0]  mem [0:MEM_WORDS-1];
  lfs_func_t   func_q;
  logic [7:0]  page_q;
  logic [7:0]  ptr_q;
  logic [7:0]  shreg_q;
  logic [7:0]  tx_q;
  logic [3:0]  bit_cnt_q;
  logic        rw_q;
  logic        mack_q;
  lfs_state_t  st_q;
  logic [7:0]  rd_val;
  logic        wr_fire;
  logic        frame_page;
  logic        restart;
  logic        restart_q;

  assign frame_page = (page_q < 8'(NUM_PAGES));
  assign wr_fire    = (st_q == ST_WDATA) && scl_fall && (bit_cnt_q == 4'h8);
  assign restart    = wr_fire && (page_q == FUNC_PAGE) && (ptr_q != PAGE_SEL_ADDR) &&
                      ((ptr_q == CFG_ADDR) || (ptr_q == PLAY_ADDR));

  always_comb begin
    rd_val = 8'h00;
    if (ptr_q == PAGE_SEL_ADDR) begin
      rd_val = page_q;
    end else if (frame_page) begin
      if (!func_q.soft_shutdown_bit && ptr_q < PAGE_END) begin
        rd_val = mem[mem_idx(page_q[2:0], ptr_q)];
      end
    end else if (page_q == FUNC_PAGE) begin
      case (ptr_q)
        CFG_ADDR:   rd_val = 8'(func_q.mode) << MODE_LSB | 8'(func_q.first) << FIRST_LSB;
        STILL_ADDR: rd_val = 8'(func_q.still) << STILL_LSB;
        PLAY_ADDR:  rd_val = 8'(func_q.loops) << LOOP_LSB | 8'(func_q.frames) << FCOUNT_LSB;
        SHDN_ADDR:  rd_val = 8'(func_q.soft_shutdown_bit) << SHDN_LSB;
        default:    rd_val = 8'h00;
      endcase
    end
  end

  // Frame bytes: on/off, blink, duty share one flat page
  always_ff @(posedge mclk_i) begin
    if (wr_fire && ptr_q != PAGE_SEL_ADDR && frame_page && ptr_q < PAGE_END) begin
      mem[mem_idx(page_q[2:0], ptr_q)] <= shreg_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      page_q <= REG_RESET;
      func_q <= '0;
    end else if (wr_fire) begin
      if (ptr_q == PAGE_SEL_ADDR) begin
        page_q <= shreg_q;
      end else if (page_q == FUNC_PAGE) begin
        case (ptr_q)
          CFG_ADDR: begin
            func_q.mode  <= shreg_q[MODE_LSB +: 2];
            func_q.first <= shreg_q[FIRST_LSB +: 3];
          end
          STILL_ADDR: func_q.still <= shreg_q[STILL_LSB +: 3];
          PLAY_ADDR: begin
            func_q.loops  <= shreg_q[LOOP_LSB +: 3];
            func_q.frames <= shreg_q[FCOUNT_LSB +: 3];
          end
          SHDN_ADDR: func_q.soft_shutdown_bit <= shreg_q[SHDN_LSB];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q      <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shreg_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      mack_q    <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else if (bus_start) begin
      st_q      <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_o  <= 1'b0;
    end else if (bus_stop) begin
      st_q     <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && bit_cnt_q != 4'h8) begin
            shreg_q   <= {shreg_q[6:0], sda_f};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            if (st_q == ST_ADDR) begin
              if (shreg_q[7:1] == DEV_ADDR) begin
                sda_oe_o <= 1'b1;
                rw_q     <= shreg_q[0];
                st_q     <= ST_AACK;
              end else begin
                st_q <= ST_IDLE;
              end
            end else if (st_q == ST_REG) begin
              ptr_q    <= shreg_q;
              sda_oe_o <= 1'b1;
              st_q     <= ST_RACK;
            end else begin
              sda_oe_o <= 1'b1;
              st_q     <= ST_WACK;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              tx_q     <= rd_val;
              sda_oe_o <= ~rd_val[7];
              ptr_q    <= ptr_q + 8'h01;
              st_q     <= ST_RDATA;
            end else begin
              sda_oe_o <= 1'b0;
              st_q     <= ST_REG;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            st_q     <= ST_WDATA;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            ptr_q    <= ptr_q + 8'h01;
            st_q     <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              sda_oe_o  <= 1'b0;
              st_q      <= ST_MACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_o <= ~tx_q[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_q <= ~sda_f;
          end else if (scl_fall) begin
            if (mack_q) begin
              tx_q     <= rd_val;
              sda_oe_o <= ~rd_val[7];
              ptr_q    <= ptr_q + 8'h01;
              st_q     <= ST_RDATA;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge mclk_i) begin
    sda_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame playback
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic [2:0]  step_q;
  logic [2:0]  loop_q;
  logic [3:0]  nfr;
  logic        tick;

  assign nfr  = (func_q.frames == 3'h0) ? 4'(NUM_PAGES) : {1'b0, func_q.frames};
  assign tick = (tick_cnt_q == 32'(FRAME_TICKS - 1));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tick_cnt_q  <= 32'h0;
      step_q      <= 3'h0;
      loop_q      <= 3'h0;
      cur_frame_o <= 3'h0;
      play_done_o <= 1'b0;
      restart_q   <= 1'b0;
    end else begin
      // One cycle late so playback sees the fields just written
      restart_q  <= restart;
      tick_cnt_q <= (tick || restart_q) ? 32'h0 : tick_cnt_q + 32'h1;
      if (func_q.mode == MODE_STILL) begin
        cur_frame_o <= func_q.still;
        play_done_o <= 1'b0;
      end else if (func_q.mode == MODE_AUTO) begin
        if (restart_q) begin
          cur_frame_o <= func_q.first;
          step_q      <= 3'h0;
          loop_q      <= 3'h0;
          play_done_o <= 1'b0;
        end else if (tick && !play_done_o) begin
          if ({1'b0, step_q} + 4'h1 < nfr) begin
            step_q      <= step_q + 3'h1;
            cur_frame_o <= func_q.first + step_q + 3'h1;
          end else if (func_q.loops == 3'h0 || loop_q + 3'h1 < func_q.loops) begin
            step_q      <= 3'h0;
            loop_q      <= loop_q + 3'h1;
            cur_frame_o <= func_q.first;
          end else begin
            play_done_o <= 1'b1;
            cur_frame_o <= func_q.first + nfr[2:0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // LED output
  // ----------------------------------------------------------------
  logic [7:0]  pwm_cnt_q;
  logic [31:0] blink_cnt_q;
  logic        blink_ph_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pwm_cnt_q   <= 8'h00;
      blink_cnt_q <= 32'h0;
      blink_ph_q  <= 1'b1;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      if (blink_cnt_q == 32'(BLINK_TICKS - 1)) begin
        blink_cnt_q <= 32'h0;
        blink_ph_q  <= ~blink_ph_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h1;
      end
    end
  end

  // Comparator per LED: duty/256 of each 256-cycle window
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      led_o <= '0;
    end else begin
      for (int i = 0; i < NUM_LEDS; i++) begin
        led_o[i] <= func_q.soft_shutdown_bit
                  & mem[mem_idx(cur_frame_o, ON_OFF_BASE + 8'(i / 8))][i % 8]
                  & (~mem[mem_idx(cur_frame_o, BLINK_BASE + 8'(i / 8))][i % 8]
                     | blink_ph_q)
                  & (mem[mem_idx(cur_frame_o, DUTY_BASE + 8'(i))] > pwm_cnt_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  logic [7:0] duty0;
  assign duty0 = mem[mem_idx(cur_frame_o, DUTY_BASE)];

  property p_still;
    (func_q.mode == MODE_STILL) |=> (cur_frame_o == $past(func_q.still));
  endproperty
  a_still: assert property (p_still) else $error("still frame not shown");

  property p_audio_hold;
    func_q.mode[1] |=> $stable(cur_frame_o);
  endproperty
  a_audio_hold: assert property (p_audio_hold) else $error("frame moved in audio mode");

  property p_start;
    (restart_q && func_q.mode == MODE_AUTO) |=> (cur_frame_o == $past(func_q.first)) && !play_done_o;
  endproperty
  a_start: assert property (p_start) else $error("playback did not start at first frame");

  property p_endless;
    (func_q.loops == 3'h0 && !restart && !play_done_o) |=> !play_done_o;
  endproperty
  a_endless: assert property (p_endless) else $error("endless playback finished");

  property p_stop_frame;
    $rose(play_done_o) |-> (cur_frame_o == 3'(func_q.first + nfr[2:0]));
  endproperty
  a_stop_frame: assert property (p_stop_frame) else $error("wrong stop frame");

  property p_page_sel;
    (wr_fire && ptr_q == PAGE_SEL_ADDR) |=> (page_q == $past(shreg_q));
  endproperty
  a_page_sel: assert property (p_page_sel) else $error("page select not stored");

  property p_frame_read;
    (frame_page && func_q.soft_shutdown_bit && ptr_q != PAGE_SEL_ADDR) |-> (rd_val == 8'h00);
  endproperty
  a_frame_read: assert property (p_frame_read) else $error("frame read while running");

  property p_unused_zero;
    (page_q == FUNC_PAGE && ptr_q == PLAY_ADDR) |-> (rd_val[7] == 1'b0 && rd_val[3] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit reads one");

  property p_dark;
    (duty0 == 8'h00) ##1 (duty0 == 8'h00) |-> !led_o[0];
  endproperty
  a_dark: assert property (p_dark) else $error("zero duty LED lit");

  c_write:  cover property (wr_fire && frame_page);
  c_read:   cover property (st_q == ST_MACK ##1 st_q == ST_RDATA);
  c_done:   cover property ($rose(play_done_o));
  c_func:   cover property (wr_fire && page_q == FUNC_PAGE && ptr_q == CFG_ADDR);

endmodule

// file: src/lfs_pin_sync.sv
module lfs_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Idle bus lines rest high
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s1_q    <= '1;
      s2_q    <= '1;
      s3_q    <= '1;
      level_o <= '1;
    end else begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_o <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_o);
    end
  end

endmodule

// file: src/lfs_pkg.sv
package lfs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int FRAME_TIME_MS = 704;
  localparam int BLINK_TIME_MS = 270;
  localparam int FRAME_CYC     = FRAME_TIME_MS * (CLK_HZ / 1000);
  localparam int BLINK_CYC     = BLINK_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Frame page layout
  // ----------------------------------------------------------------
  localparam int         NUM_LEDS      = 144;
  localparam int         NUM_PAGES     = 8;
  localparam int         PAGE_BYTES    = 180;
  localparam int         MEM_WORDS     = NUM_PAGES * PAGE_BYTES;
  localparam logic [7:0] ON_OFF_BASE   = 8'h00;
  localparam logic [7:0] BLINK_BASE    = 8'h12;
  localparam logic [7:0] DUTY_BASE     = 8'h24;
  localparam logic [7:0] PAGE_END      = 8'hb4;

  // ----------------------------------------------------------------
  // Page select and function page
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hfd;
  localparam logic [7:0] FUNC_PAGE     = 8'h0b;
  localparam logic [7:0] CFG_ADDR      = 8'h00;
  localparam logic [7:0] STILL_ADDR    = 8'h01;
  localparam logic [7:0] PLAY_ADDR     = 8'h02;
  localparam logic [7:0] SHDN_ADDR     = 8'h0a;
  localparam int         MODE_LSB      = 3;
  localparam int         FIRST_LSB     = 0;
  localparam int         STILL_LSB     = 0;
  localparam int         LOOP_LSB      = 4;
  localparam int         FCOUNT_LSB    = 0;
  localparam int         SHDN_LSB      = 0;
  localparam logic [1:0] MODE_STILL    = 2'b00;
  localparam logic [1:0] MODE_AUTO     = 2'b01;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [6:0] DEV_ADDR      = 7'h50;  // Arbitrary bus address

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] first;
    logic [2:0] still;
    logic [2:0] loops;
    logic [2:0] frames;
    logic       soft_shutdown_bit;  // 0 = shutdown, 1 = running
  } lfs_func_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_ADDR  = 4'b0001,
    ST_AACK  = 4'b0011,
    ST_REG   = 4'b0010,
    ST_RACK  = 4'b0110,
    ST_WDATA = 4'b0111,
    ST_WACK  = 4'b0101,
    ST_RDATA = 4'b0100,
    ST_MACK  = 4'b1100
  } lfs_state_t;

endpackage

// file: tb/led_matrix_frame_store_tb_top.sv
module led_matrix_frame_store_tb_top
  import lfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                mclk;
  logic                rst_n;
  logic                scl;
  logic                host_oe;
  logic                dut_sda;
  logic                dut_oe;
  logic [NUM_LEDS-1:0] led;
  logic [2:0]          cur_frame;
  logic                play_done;
  logic                sda_w;
  int                  n_errors;
  int                  checks_done;
  int                  n;
  int                  mv;
  int                  jp;
  logic [2:0]          held;
  logic [15:0]         w2;

  // Pull-up wins unless a party pulls low
  assign sda_w = !host_oe && !(dut_oe && !dut_sda);

  lfs_frame_store #(
    .FRAME_TICKS (100),
    .BLINK_TICKS (16)
  ) dut (
    .mclk_i      (mclk),
    .rst_n_i     (rst_n),
    .scl_i       (scl),
    .sda_i       (sda_w),
    .sda_o       (dut_sda),
    .sda_oe_o    (dut_oe),
    .led_o       (led),
    .cur_frame_o (cur_frame),
    .play_done_o (play_done)
  );

  lfs_host_model host (
    .mclk_i   (mclk),
    .sda_i    (sda_w),
    .scl_o    (scl),
    .sda_oe_o (host_oe)
  );

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] r, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(r, d);
    check(what, d, exp);
  endtask

  // Two bytes in one transfer, second lands via pointer increment
  task automatic wr2(input logic [7:0] r, input logic [7:0] d0, input logic [7:0] d1);
    host.start();
    host.sb({DEV_ADDR, 1'b0});
    host.sb(r);
    host.sb(d0);
    host.sb(d1);
    host.end_frame();
  endtask

  // Two-byte read, master ACK keeps the device sending
  task automatic rd2(input logic [7:0] r, output logic [15:0] d);
    logic s;
    host.start();
    host.sb({DEV_ADDR, 1'b0});
    host.sb(r);
    host.start();
    host.sb({DEV_ADDR, 1'b1});
    for (int i = 15; i >= 0; i--) begin
      host.bit_io(1'b1, d[i]);
      if (i == 8) host.bit_io(1'b0, s);
    end
    host.bit_io(1'b1, s);
    host.end_frame();
  endtask

  task automatic lit_count(input int idx);
    n = 0;
    repeat (256) begin
      @(posedge mclk);
      #1;
      if (led[idx] === 1'b1) n++;
    end
  endtask

  task automatic watch(input int cyc);
    logic [2:0] prev;
    mv = 0;
    jp = 0;
    prev = cur_frame;
    for (int i = 0; i < cyc && play_done !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
      if (cur_frame !== prev) mv++;
      if (cur_frame !== prev && cur_frame !== prev + 3'h1) jp++;
      prev = cur_frame;
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    n_errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    check("reset_outputs", {dut_oe, dut_sda, |led, cur_frame, play_done}, 0);
    host.start();
    host.sb({7'h51, 1'b0});
    host.end_frame();
    check("foreign_addr_ack", host.acks_ok, 1'b0);
    host.acks_ok = 1'b1;
    host.wr(PAGE_SEL_ADDR, FUNC_PAGE);
    for (int r = 0; r < 3; r++) rd_chk("fn_reset", r[7:0], REG_RESET);
    host.wr(CFG_ADDR, 8'he7);
    rd_chk("cfg_unused", CFG_ADDR, 8'h07);
    host.wr(PLAY_ADDR, 8'hff);
    rd_chk("play_unused", PLAY_ADDR, 8'h77);
    host.wr(STILL_ADDR, 8'hff);
    rd_chk("still_unused", STILL_ADDR, 8'h07);
    for (int k = 0; k < 8; k++) begin
      host.wr(STILL_ADDR, k[7:0]);
      repeat (3) @(posedge mclk);
      #1;
      check("still_frame", cur_frame, k[2:0]);
    end
    host.wr(PAGE_SEL_ADDR, 8'h00);
    wr2(8'h01, 8'h02, 8'h5a);
    host.wr(8'h11, 8'h80);
    wr2(8'h13, 8'h00, 8'h00);
    wr2(8'h23, 8'h00, 8'h00);
    host.wr(8'h2d, 8'hb5);
    host.wr(8'h34, 8'hff);
    host.wr(8'hb3, 8'hff);
    rd_chk("frame_rd_shutdown", 8'h2d, 8'hb5);
    rd2(8'h01, w2);
    check("frame_increment", w2, 16'h025a);
    host.wr(PAGE_SEL_ADDR, 8'h0c);
    host.wr(8'h2d, 8'h11);
    host.wr(PAGE_SEL_ADDR, 8'h00);
    rd_chk("reserved_page", 8'h2d, 8'hb5);
    host.wr(PAGE_SEL_ADDR, FUNC_PAGE);
    host.wr(STILL_ADDR, 8'h00);
    host.wr(SHDN_ADDR, 8'h01);
    rd_chk("fn_rd_running", SHDN_ADDR, 8'h01);
    host.wr(PAGE_SEL_ADDR, 8'h00);
    rd_chk("frame_rd_running", 8'h2d, 8'h00);
    lit_count(9);
    check("duty_fraction", n, 181);
    lit_count(16);
    check("led_off_bit", n, 0);
    lit_count(143);
    check("last_duty", n, 255);
    host.wr(8'h13, 8'h02);
    lit_count(9);
    check("blink_dims", n inside {[40:140]}, 1'b1);
    host.wr(PAGE_SEL_ADDR, FUNC_PAGE);
    host.wr(PLAY_ADDR, 8'h33);
    host.wr(CFG_ADDR, 8'h0b);
    check("auto_first", cur_frame, 3'h3);
    watch(1500);
    repeat (2) @(posedge mclk);
    #1;
    check("auto_wraps", jp, 2);
    check("auto_stop", {cur_frame, play_done}, {3'h6, 1'b1});
    host.wr(PLAY_ADDR, 8'h00);
    host.wr(CFG_ADDR, 8'h0e);
    check("endless_first", cur_frame, 3'h6);
    watch(1200);
    check("endless_steps", {mv[7:0], jp[7:0], play_done}, {8'd12, 8'd0, 1'b0});
    for (int m = 0; m < 2; m++) begin
      host.wr(CFG_ADDR, m ? 8'h18 : 8'h10);
      held = cur_frame;
      watch(400);
      check("audio_hold", {mv[7:0], cur_frame}, {8'd0, held});
    end
    check("acks", host.acks_ok, 1'b1);
    tally_and_finish();
  end
endmodule

// file: tb/lfs_host_model.sv
module lfs_host_model
  import lfs_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Bus master, SCL phases of 10-12 mclk per bit, at least 20 high at START and STOP
  // ----------------------------------------
  logic acks_ok;

  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    acks_ok = 1'b1;
  end

  task automatic half();
    repeat (10) @(posedge mclk_i);
    #1;
  endtask

  // SDA moves two cycles after SCL falls, never beside the edge
  task automatic bit_io(input logic b, output logic s);
    repeat (2) @(posedge mclk_i);
    #1;
    sda_oe_o = ~b;
    half();
    scl_o = 1'b1;
    half();
    s = sda_i;
    scl_o = 1'b0;
  endtask

  task automatic start();
    sda_oe_o = 1'b0;
    half();
    scl_o = 1'b1;
    half();
    sda_oe_o = 1'b1;
    half();
    scl_o = 1'b0;
  endtask

  task automatic stop();
    bit_io(1'b0, acks_ok);
    acks_ok = 1'b1;
  endtask

  task automatic sb(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    acks_ok &= ~s;
  endtask

  task automatic finish_stop();
    scl_o = 1'b1;
    half();
    sda_oe_o = 1'b0;
    half();
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    start();
    sb({DEV_ADDR, 1'b0});
    sb(r);
    sb(d);
    end_frame();
  endtask

  // Single-byte reads close with a NACK
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic s;
    start();
    sb({DEV_ADDR, 1'b0});
    sb(r);
    start();
    sb({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, s);
    end_frame();
  endtask

  task automatic end_frame();
    repeat (2) @(posedge mclk_i);
    #1;
    sda_oe_o = 1'b1;
    half();
    finish_stop();
  endtask
endmodule
